// [hdl/pdm_consts.vh]
// Constants for the power-down mode controller
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH

// ----------------------------------------
// Instruction opcodes
// ----------------------------------------
`define PDM_OP_STOP 8'h7F
`define PDM_OP_IDLE 8'h6F

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PDM_OFS_CLK_CTRL 8'h00
`define PDM_OFS_STOP_CTRL 8'h04
`define PDM_OFS_BT_CTRL 8'h08
`define PDM_OFS_IMR 8'h0C
`define PDM_OFS_EXTCON 8'h10
`define PDM_OFS_STATUS 8'h14

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define PDM_CLK_CTRL_RST 8'h00
`define PDM_STOP_CTRL_RST 8'h00
`define PDM_BT_CTRL_RST 8'h00
`define PDM_IMR_RST 8'h00
`define PDM_EXTCON_RST 8'h00
`define PDM_STOP_KEY 8'hA5
`define PDM_DIV_HI 4
`define PDM_DIV_LO 3
`define PDM_CAP_EN_BIT 3
`define PDM_START_ADDR 16'h0100
`define PDM_FILT_LEN 4

`endif

// [hdl/pdm_noise_filter.v]
// Noise filter for the external wake lines, one stage per line
`timescale 1ns/10ps
`default_nettype none
module pdm_noise_filter #(
  parameter WIDTH = 4,
  parameter LEN = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire ce,
  input wire [WIDTH-1:0] raw_in,
  output wire [WIDTH-1:0] clean_out
);
  genvar g;
  // ----------------------------------------
  // Per-line stable-level filter
  // ----------------------------------------
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_line
      reg [7:0] cnt_r;
      reg out_r;
      // Output follows input only after LEN equal samples, rejecting glitches
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          cnt_r <= 8'h00;
          out_r <= 1'b0;
        end else if (ce) begin
          if (raw_in[g] == out_r) begin
            cnt_r <= 8'h00;
          end else if (cnt_r == LEN[7:0] - 8'h01) begin
            cnt_r <= 8'h00;
            out_r <= raw_in[g];
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
      end
      assign clean_out[g] = out_r;
    end
  endgenerate
endmodule
`default_nettype wire

// [hdl/pdm_stab_timer.v]
// Oscillation stabilization counter driven by the basic timer setting
`timescale 1ns/10ps
`default_nettype none
module pdm_stab_timer #(
  parameter STAB_UNIT = 256
) (
  input wire sys_clk,
  input wire rst_n,
  input wire ce,
  input wire start,
  input wire [1:0] sel,
  output reg done_r
);
  reg [19:0] cnt_r;
  reg run_r;
  wire [19:0] unit_w;
  wire [19:0] limit_w;

  // Interval is the unit scaled by 4 per select step
  assign unit_w = STAB_UNIT[19:0];
  assign limit_w = unit_w << {sel, 1'b0};

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // A new start restarts the count; done is a one-cycle pulse
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r <= 20'h00000;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (start) begin
        cnt_r <= 20'h00001;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r >= limit_w) begin
          run_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 20'h00001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/pdm_power_ctrl.v]
// Power-down mode controller: Stop/Idle sequencing with AHB-Lite registers
`timescale 1ns/10ps
`default_nettype none
`include "pdm_consts.vh"
module pdm_power_ctrl #(
  parameter STAB_UNIT = 256,
  parameter FILT_LEN = `PDM_FILT_LEN
) (
  input wire sys_clk,
  input wire rst_n,
  input wire ce,
  input wire ext_reset,
  input wire instr_valid,
  input wire [7:0] instr_opcode,
  input wire [7:0] irq_req,
  input wire ext_irq_line_a,
  input wire ext_irq_line_b,
  input wire ext_irq_line_c,
  input wire timer0_capture_pin,
  input wire vsync_out,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg osc_en_r,
  output reg cpu_clk_en_r,
  output reg periph_clk_en_r,
  output reg [1:0] cpu_div_sel_r,
  output reg port_dir_hold_r,
  output reg ctrl_defaults_r,
  output reg core_start_r,
  output reg [15:0] start_addr_r,
  output reg irq_service_r,
  output reg [3:0] wake_src_r
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  // State meanings:
  //   RUN   - CPU clocked, opcodes decoded, no power saving active
  //   IDLE  - CPU clock gated, oscillator and peripherals still running
  //   STOP  - oscillator, CPU and peripherals halted, registers kept
  //   STAB  - oscillator restarted, CPU held until the interval ends
  //   RHOLD - reset pin active, control registers forced to defaults
  // Reset and interrupt wakes share STAB; a flag remembers which one
  // started it so the hand-off pulse goes to the right CPU input.
  //
  // Register map, one byte per aligned word except the 12-bit status, upper bits read zero:
  //   00 clock control: bits 4:3 pick the CPU clock divider
  //   04 stop control: Stop is refused unless it holds the key value
  //   08 basic timer control: bits 1:0 pick the stabilization interval
  //   0C interrupt mask: one bit per request level
  //   10 external line control: bits 2:0 enable lines a to c,
  //      bit 3 capture mode, bits 6:4 edge polarity (1 = rising)
  //   14 status, read only: filtered lines, last Stop wake source, state
  //
  // Limitation: the key check makes a stray stop opcode harmless only until the key is written, at
  // the price of one extra register write before the first Stop entry after a reset.
  localparam [2:0] ST_RUN = 3'b000;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_STOP = 3'b010;
  localparam [2:0] ST_STAB = 3'b011;
  localparam [2:0] ST_RHOLD = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg stab_irq_r;
  reg [7:0] clock_control_reg;
  reg [7:0] stop_control_reg;
  reg [7:0] basic_timer_ctrl_reg;
  reg [7:0] irq_mask_reg;
  reg [7:0] ext_irq_ctrl_reg;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg [3:0] filt_prev_r;
  reg vsync_prev_r;
  reg stab_start;
  wire [3:0] filt_w;
  wire [3:0] edge_w;
  wire [3:0] stop_wake_w;
  wire vs_edge_w;
  wire idle_wake_w;
  wire stab_done_w;
  wire op_stop_w;
  wire op_idle_w;
  wire addr_ok_w;

  // ----------------------------------------
  // Wake sources
  // ----------------------------------------
  // All four external lines pass the RC-style filter before use
  pdm_noise_filter #(
    .WIDTH(4),
    .LEN(FILT_LEN)
  ) u_filt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .raw_in({timer0_capture_pin, ext_irq_line_c, ext_irq_line_b,
      ext_irq_line_a}),
    .clean_out(filt_w)
  );

  // Edge history of the filtered lines and the sync output
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      filt_prev_r <= 4'h0;
      vsync_prev_r <= 1'b0;
    end else if (ce) begin
      filt_prev_r <= filt_w;
      vsync_prev_r <= vsync_out;
    end
  end

  // Line polarity bits 6:4 pick rising (1) or falling (0) edges
  assign edge_w[0] = ext_irq_ctrl_reg[4] ? (filt_w[0] & ~filt_prev_r[0])
    : (~filt_w[0] & filt_prev_r[0]);
  assign edge_w[1] = ext_irq_ctrl_reg[5] ? (filt_w[1] & ~filt_prev_r[1])
    : (~filt_w[1] & filt_prev_r[1]);
  assign edge_w[2] = ext_irq_ctrl_reg[6] ? (filt_w[2] & ~filt_prev_r[2])
    : (~filt_w[2] & filt_prev_r[2]);
  // Capture fires on either edge of the pin or the sync output
  assign vs_edge_w = vsync_out ^ vsync_prev_r;
  assign edge_w[3] = (filt_w[3] ^ filt_prev_r[3]) | vs_edge_w;

  // Stop wake: only enabled filtered lines and capture-mode timer0
  assign stop_wake_w[2:0] = edge_w[2:0] & ext_irq_ctrl_reg[2:0];
  assign stop_wake_w[3] = edge_w[3] &
    ext_irq_ctrl_reg[`PDM_CAP_EN_BIT];
  // Idle wake: any unmasked request; all masked leaves only reset
  assign idle_wake_w = |(irq_req & irq_mask_reg);

  // Stop needs the key in the stop control register alongside the opcode
  assign op_stop_w = instr_valid && (instr_opcode == `PDM_OP_STOP) &&
    (stop_control_reg == `PDM_STOP_KEY);
  assign op_idle_w = instr_valid &&
    (instr_opcode == `PDM_OP_IDLE);

  // ----------------------------------------
  // Stabilization timer
  // ----------------------------------------
  pdm_stab_timer #(
    .STAB_UNIT(STAB_UNIT)
  ) u_stab (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(stab_start),
    .sel(basic_timer_ctrl_reg[1:0]),
    .done_r(stab_done_w)
  );

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  // Next state; reset pin overrides everything
  always @* begin
    state_nxt = state_r;
    stab_start = 1'b0;
    if (ext_reset) begin
      state_nxt = ST_RHOLD;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (op_stop_w) begin
            state_nxt = ST_STOP;
          end else if (op_idle_w) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (idle_wake_w) begin
            state_nxt = ST_RUN;
          end
        end
        ST_STOP: begin
          // Besides the reset pin, only a qualifying external edge leaves Stop
          if (|stop_wake_w) begin
            state_nxt = ST_STAB;
            stab_start = 1'b1;
          end
        end
        ST_RHOLD: begin
          state_nxt = ST_STAB;
          stab_start = 1'b1;
        end
        ST_STAB: begin
          if (stab_done_w) begin
            state_nxt = ST_RUN;
          end
        end
        default: begin
          state_nxt = ST_RUN;
        end
      endcase
    end
  end

  // State register and wake bookkeeping
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_RHOLD;
      stab_irq_r <= 1'b0;
      wake_src_r <= 4'h0;
    end else if (ce) begin
      state_r <= state_nxt;
      if (ext_reset) begin
        stab_irq_r <= 1'b0;
      end else if (state_r == ST_STOP && (|stop_wake_w)) begin
        stab_irq_r <= 1'b1;
        wake_src_r <= stop_wake_w;
      end else if (state_r == ST_RHOLD) begin
        stab_irq_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Clock gating and CPU hand-off outputs
  // ----------------------------------------
  // Oscillator and peripherals stop only in Stop; CPU clock runs only in
  // Run, so the stabilization wait never lets the CPU see an unsettled clock
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      osc_en_r <= 1'b1;
      cpu_clk_en_r <= 1'b0;
      periph_clk_en_r <= 1'b1;
      port_dir_hold_r <= 1'b0;
      ctrl_defaults_r <= 1'b1;
      core_start_r <= 1'b0;
      start_addr_r <= `PDM_START_ADDR;
      irq_service_r <= 1'b0;
      cpu_div_sel_r <= 2'b00;
    end else if (ce) begin
      osc_en_r <= (state_nxt != ST_STOP);
      periph_clk_en_r <= (state_nxt != ST_STOP);
      cpu_clk_en_r <= (state_nxt == ST_RUN);
      port_dir_hold_r <= (state_nxt == ST_IDLE);
      ctrl_defaults_r <= ext_reset;
      start_addr_r <= `PDM_START_ADDR;
      // Reset path restarts the core at the reset vector
      core_start_r <= (state_r == ST_STAB) && stab_done_w &&
        !stab_irq_r && !ext_reset;
      // Interrupt path resumes in place and takes the interrupt at once
      irq_service_r <= !ext_reset && (((state_r == ST_STAB) && stab_done_w &&
        stab_irq_r) || ((state_r == ST_IDLE) && idle_wake_w));
      // Divider tracks bits 4:3; an interrupt wake keeps the old choice
      cpu_div_sel_r <= clock_control_reg[`PDM_DIV_HI:`PDM_DIV_LO];
    end
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Word-aligned offsets inside the low byte; anything else is unmapped
  assign addr_ok_w = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);

  // Zero wait state: read data is captured in the address phase.
  // Writes are remembered in the address phase and land with the data
  // phase edge, since hwdata is only valid one cycle after the address.
  // A read issued right after a write to the same offset therefore
  // still sees the old value: the write lands at the edge that takes the
  // read address phase, and the read mux samples the pre-edge registers.
  // Only whole-word transfers update a register; narrower sizes are
  // dropped silently because the response is always OKAY.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pend_r <= hsel && htrans[1] && hwrite && addr_ok_w &&
          (hsize == 3'b010);
        wr_addr_r <= haddr[7:0];
        if (hsel && htrans[1] && !hwrite) begin
          case (addr_ok_w ? haddr[7:0] : 8'hFF)
            `PDM_OFS_CLK_CTRL: hrdata <= {24'h000000, clock_control_reg};
            `PDM_OFS_STOP_CTRL: hrdata <= {24'h000000, stop_control_reg};
            `PDM_OFS_BT_CTRL: hrdata <= {24'h000000, basic_timer_ctrl_reg};
            `PDM_OFS_IMR: hrdata <= {24'h000000, irq_mask_reg};
            `PDM_OFS_EXTCON: hrdata <= {24'h000000, ext_irq_ctrl_reg};
            `PDM_OFS_STATUS: hrdata <= {20'h00000, filt_w, wake_src_r,
              1'b0, state_r};
            default: hrdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // The reset pin returns every control register to default; a Stop wake
  // by interrupt never touches them, so their values survive Stop.
  // Data held elsewhere in the core is not reset here at all, which
  // is what keeps data registers intact across a reset-pin wake.
  // Hazard: a write in flight while the reset pin rises is lost; the
  // reset branch wins so defaults are always clean afterwards.
  always @(posedge sys_clk) begin
    if (!rst_n || ext_reset) begin
      clock_control_reg <= `PDM_CLK_CTRL_RST;
      stop_control_reg <= `PDM_STOP_CTRL_RST;
      basic_timer_ctrl_reg <= `PDM_BT_CTRL_RST;
      irq_mask_reg <= `PDM_IMR_RST;
      ext_irq_ctrl_reg <= `PDM_EXTCON_RST;
    end else if (ce && wr_pend_r) begin
      // Only writes change these, never a wake event
      case (wr_addr_r)
        `PDM_OFS_CLK_CTRL: clock_control_reg <= hwdata[7:0];
        `PDM_OFS_STOP_CTRL: stop_control_reg <= hwdata[7:0];
        `PDM_OFS_BT_CTRL: basic_timer_ctrl_reg <= hwdata[7:0];
        `PDM_OFS_IMR: irq_mask_reg <= hwdata[7:0];
        `PDM_OFS_EXTCON: ext_irq_ctrl_reg <= hwdata[7:0];
        default: irq_mask_reg <= irq_mask_reg;
      endcase
    end
  end
endmodule
`default_nettype wire

// [tb/pdm_wake_model.sv]
// Far-side model: wake pins, capture input, vertical sync and reset pin
`timescale 1ns/10ps
`default_nettype none
module pdm_wake_model (
  input wire logic sys_clk,
  input wire logic [5:0] req,
  output logic ext_irq_line_a,
  output logic ext_irq_line_b,
  output logic ext_irq_line_c,
  output logic timer0_capture_pin,
  output logic vsync_out,
  output logic ext_reset
);
  // -------------------------------------------
  // Pin drivers
  // -------------------------------------------
  // Levels change just after an edge and are held for many cycles,
  // so the noise filter always sees a clean, settled edge
  initial begin
    {ext_reset, vsync_out, timer0_capture_pin} = 3'h0;
    {ext_irq_line_c, ext_irq_line_b, ext_irq_line_a} = 3'h0;
  end
  always @(posedge sys_clk) begin
    ext_irq_line_a <= req[0];
    ext_irq_line_b <= req[1];
    ext_irq_line_c <= req[2];
    timer0_capture_pin <= req[3];
    vsync_out <= req[4];
    ext_reset <= req[5];
  end
endmodule
`default_nettype wire

// [tb/pdm_power_sva.sv]
// Checker of the power-down controller's port behaviour
`timescale 1ns/10ps
`default_nettype none
module pdm_power_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic ext_reset,
  input wire logic instr_valid,
  input wire logic [7:0] instr_opcode,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic osc_en_r,
  input wire logic cpu_clk_en_r,
  input wire logic periph_clk_en_r,
  input wire logic [1:0] cpu_div_sel_r,
  input wire logic port_dir_hold_r,
  input wire logic ctrl_defaults_r,
  input wire logic core_start_r,
  input wire logic [15:0] start_addr_r,
  input wire logic irq_service_r
);
  // -------------------------------------------
  // Assertions
  // -------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not OKAY");
  a_stop_entry: assert property ($fell(osc_en_r) |->
    $past(instr_valid && instr_opcode == 8'h7F))
    else $error("oscillator stopped without stop opcode");
  a_idle_entry: assert property (ce && cpu_clk_en_r && !ext_reset &&
    instr_valid && instr_opcode == 8'h6F |=> !cpu_clk_en_r)
    else $error("idle opcode did not stop cpu clock");
  a_stop_halt: assert property (!osc_en_r |->
    !cpu_clk_en_r && !periph_clk_en_r)
    else $error("clock running while oscillator is off");
  a_idle_clocks: assert property (port_dir_hold_r |->
    osc_en_r && periph_clk_en_r && !cpu_clk_en_r)
    else $error("idle clock gating wrong");
  a_stab_hold: assert property ($rose(osc_en_r) |->
    !cpu_clk_en_r [*4])
    else $error("cpu clock before stabilization");
  a_reset_div: assert property (ext_reset [*3] |->
    cpu_div_sel_r == 2'b00 && ctrl_defaults_r)
    else $error("reset did not select slow clock");
  a_start_addr: assert property (core_start_r |->
    start_addr_r == 16'h0100)
    else $error("wrong start address");
  a_wake_service: assert property (irq_service_r |->
    cpu_clk_en_r && osc_en_r)
    else $error("service without running cpu clock");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the power-down controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic instr_valid = 1'b0;
  logic [7:0] instr_opcode = 8'h00;
  logic [7:0] irq_req = 8'h00;
  logic [5:0] src = 6'h00;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hreadyout, hresp, osc, cpu, per, hold, defs, start, svc;
  wire logic line_a, line_b, line_c, cap, vs, ext_reset;
  wire logic [31:0] hrdata;
  wire logic [1:0] div;
  wire logic [15:0] saddr;
  wire logic [3:0] wsrc;
  int fails = 0;
  int n_tests = 0;
  int k;
  int e;
  logic [31:0] r;

  always #5 sys_clk = ~sys_clk;

  pdm_wake_model u_far (.sys_clk(sys_clk), .req(src),
    .ext_irq_line_a(line_a), .ext_irq_line_b(line_b),
    .ext_irq_line_c(line_c), .timer0_capture_pin(cap),
    .vsync_out(vs), .ext_reset(ext_reset));

  // Small counts keep stabilization waits short
  pdm_power_ctrl #(.STAB_UNIT(4), .FILT_LEN(2)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .ext_reset(ext_reset),
    .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .irq_req(irq_req), .ext_irq_line_a(line_a), .ext_irq_line_b(line_b),
    .ext_irq_line_c(line_c), .timer0_capture_pin(cap), .vsync_out(vs),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .osc_en_r(osc),
    .cpu_clk_en_r(cpu), .periph_clk_en_r(per), .cpu_div_sel_r(div),
    .port_dir_hold_r(hold), .ctrl_defaults_r(defs), .core_start_r(start),
    .start_addr_r(saddr), .irq_service_r(svc), .wake_src_r(wsrc));

  // -------------------------------------------
  // Bus and check tasks
  // -------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Single word transfer; waits on hready in both phases
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  task op(input logic [7:0] c);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_opcode <= c;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // -------------------------------------------
  // Tests
  // -------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    k = 0;
    while (start !== 1'b1 && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    chk({start, saddr}, {1'b1, 16'h0100});
    rd(32'h00, 32'h0);
    rd(32'h04, 32'h0);
    rd(32'h08, 32'h0);
    rd(32'h40, 32'h0);
    bus(1'b1, 32'h00, 32'h18);
    rd(32'h00, 32'h18);
    op(8'h7F);
    chk(osc, 1);
    // Idle with every level masked: requests must not wake
    op(8'h6F);
    irq_req <= 8'hFF;
    repeat (8) @(posedge sys_clk);
    chk({cpu, hold}, 2'b01);
    bus(1'b1, 32'h0C, 32'h01);
    k = 0;
    while (svc !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      k++;
    end
    irq_req <= 8'h00;
    @(posedge sys_clk);
    chk({cpu, hold, div}, 4'b1011);
    bus(1'b1, 32'h04, 32'hA5);
    // Stop wake from each source: lines a, b, c, capture pin, vsync
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 32'h10, (i < 3 ? 32'h1 << i : 32'h08) | 32'h70);
      bus(1'b1, 32'h08, i % 4);
      op(8'h7F);
      chk({osc, per, cpu}, 3'b000);
      if (i == 0) begin
        src <= 6'h02;
        irq_req <= 8'hFF;
        repeat (12) @(posedge sys_clk);
        chk(osc, 0);
        src <= 6'h00;
        irq_req <= 8'h00;
        repeat (12) @(posedge sys_clk);
      end
      src <= 6'h01 << i;
      k = 0;
      while (osc !== 1'b1 && k < 100) begin
        @(posedge sys_clk);
        k++;
      end
      k = 0;
      while (svc !== 1'b1 && k < 2000) begin
        @(posedge sys_clk);
        k++;
      end
      e = 4 << (2 * (i % 4));
      chk(k >= e && k <= e + 6, 1);
      chk(wsrc, i < 3 ? 4'h1 << i : 4'h8);
      chk(div, 2'b11);
      rd(32'h00, 32'h18);
      src <= 6'h00;
      repeat (8) @(posedge sys_clk);
    end
    // Reset pin ends Stop and restores control defaults
    bus(1'b1, 32'h08, 32'h0);
    op(8'h7F);
    src <= 6'h20;
    repeat (4) @(posedge sys_clk);
    chk({defs, div}, 3'b100);
    src <= 6'h00;
    k = 0;
    while (start !== 1'b1 && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    chk({start, saddr}, {1'b1, 16'h0100});
    rd(32'h00, 32'h0);
    rd(32'h04, 32'h0);
    end_of_test();
  end

  // Whole run needs several hundred cycles
  initial begin
    #500000;
    fails++;
    end_of_test();
  end
endmodule

bind pdm_power_ctrl pdm_power_sva u_sva (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .ce(ce),
  .ext_reset(ext_reset),
  .instr_valid(instr_valid),
  .instr_opcode(instr_opcode),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .osc_en_r(osc_en_r),
  .cpu_clk_en_r(cpu_clk_en_r),
  .periph_clk_en_r(periph_clk_en_r),
  .cpu_div_sel_r(cpu_div_sel_r),
  .port_dir_hold_r(port_dir_hold_r),
  .ctrl_defaults_r(ctrl_defaults_r),
  .core_start_r(core_start_r),
  .start_addr_r(start_addr_r),
  .irq_service_r(irq_service_r)
);
`default_nettype wire
